// file: logic/crmr_map.vh
`ifndef CRMR_MAP_VH
`define CRMR_MAP_VH
// register byte offsets
`define CRMR_OFS_CTRL    8'h00
`define CRMR_OFS_MASK    8'h04
`define CRMR_OFS_REDEF   8'h08
`define CRMR_OFS_NEWD    8'h0c
`define CRMR_OFS_STAT    8'h10
`define CRMR_OFS_BUF     8'h40
`define CRMR_BUF_SEL     7:2
`define CRMR_BUF_HI      2'b01
// controller_control_reg fields
`define CRMR_CTRL_INIT   0
`define CRMR_CTRL_CONF   1
// acceptance_mask_ctrl fields and writable bits
`define CRMR_MASK_M0     0
`define CRMR_MASK_M1     1
`define CRMR_MASK_GLOB   2
`define CRMR_MASK_REQ    4
`define CRMR_MASK_ONE    5
`define CRMR_MASK_WMASK  8'h37
// buffer_redefine_ctrl fields
`define CRMR_REDEF_LOCK  7
`define CRMR_REDEF_SEL   3:0
`define CRMR_REDEF_WMASK 8'h8f
// buffer word layout: identifier, enable, extension
`define CRMR_BUF_ID      28:0
`define CRMR_BUF_STD     28:18
`define CRMR_BUF_EN      30
`define CRMR_BUF_IDE     31
// reset values
`define CRMR_RST_BYTE    8'h00
`define CRMR_RST_WORD    32'h0000_0000
`endif

// file: logic/crmr_top.v
// How it works
// [R01] mask bit 1 makes buffer 2 mask buffer 3
// [R02] mask bit 0 makes buffer 0 mask buffer 1
// [R03] global bit spreads highest mask upward
// [R04] single shot off: always retransmit
// [R05] single shot, no requeue: drop on loss
// [R06] single shot, requeue: one retry after loss
// [R07] host writes mask only in confirmed init
// [R08] frame type from buffer extension bit only
// [R09] mask buffers never store messages
// [R10] lowest matching buffer wins
// [R11] masked buffers rank below unmasked ones
// [R12] locked buffer excluded from matching
// [R13] init request clears the redefine lock
// [R14] select field picks buffer 0 to 15
// [R15] host changes lock and select separately
// [R16] lock waits for pending store to finish
// [R17] masked store writes identifier, sets flag
// [R18] host checks new data around locking
// [R19] redefine bits 6..4 read zero
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/100ps
`include "crmr_map.vh"
module crmr_top #(
  parameter NBUF = 16
) (
  // clock and reset
  input  wire        clk,
  input  wire        reset,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg         pready_q,
  output reg  [31:0] prdata_q,
  output reg         pslverr_q,
  // received frame from protocol engine
  input  wire        rx_valid,
  input  wire [28:0] rx_id,
  input  wire        rx_ide,
  // store result to memory access engine
  output reg         store_valid_q,
  output reg  [3:0]  store_buf_q,
  output reg         store_masked_q,
  // transmit outcome from protocol engine
  input  wire        tx_start,
  input  wire        tx_err,
  input  wire        tx_arb_lost,
  input  wire        tx_done,
  output reg         tx_retry_q,
  output reg         tx_drop_q
);

  // software registers
  reg        init_req_q;
  reg        init_conf_q;
  reg [7:0]  mask_ctrl_q;
  reg [7:0]  redef_q;
  reg [15:0] new_data_q;
  reg        lock_eff_q;
  reg [31:0] buf_mem [0:NBUF-1];
  // match pipeline and single-shot retry state
  reg        pend_q;
  reg [3:0]  pend_buf_q;
  reg        pend_msk_q;
  reg [28:0] pend_id_q;
  reg        used_retry_q;

  wire m0   = mask_ctrl_q[`CRMR_MASK_M0];
  wire m1   = mask_ctrl_q[`CRMR_MASK_M1];
  wire glob = mask_ctrl_q[`CRMR_MASK_GLOB];
  wire one  = mask_ctrl_q[`CRMR_MASK_ONE];
  wire rq   = mask_ctrl_q[`CRMR_MASK_REQ];
  wire [3:0] sel = redef_q[`CRMR_REDEF_SEL];
  wire lock = redef_q[`CRMR_REDEF_LOCK];

  // bus phases: one wait state, act on the answer edge
  wire acc   = psel && penable && pready_q;
  wire wr    = acc && pwrite;
  wire is_bf = (paddr[7:6] == `CRMR_BUF_HI);
  wire [3:0] bidx = paddr[5:2];

  // compare one buffer; mask bit 1 means "ignore this bit"
  function cmp;
    input [31:0] bw;
    input [28:0] id;
    input        ide;
    input [28:0] mk;
    reg   [28:0] diff;
    begin
      diff = (bw[`CRMR_BUF_ID] ^ id) & ~mk;
      if (bw[`CRMR_BUF_IDE])
        cmp = ide && (diff == 29'h0);
      else
        cmp = !ide && (diff[`CRMR_BUF_STD] == 11'h0);
    end
  endfunction

  // mask source per buffer: 0 none, 1 mask0, 2 mask1, 3 is a mask
  function [1:0] msrc;
    input [3:0] n;
    input       a0;
    input       a1;
    input       g;
    begin
      msrc = 2'd0;
      if (n == 4'd0)
        msrc = a0 ? 2'd3 : 2'd0; // R02
      else if (n == 4'd1)
        msrc = a0 ? 2'd1 : 2'd0; // R02
      else if (n == 4'd2)
        msrc = a1 ? 2'd3 : ((g && a0) ? 2'd1 : 2'd0); // R01 R03
      else if (n == 4'd3)
        msrc = a1 ? 2'd2 : ((g && a0) ? 2'd1 : 2'd0); // R01 R03
      else if (g)
        msrc = a1 ? 2'd2 : (a0 ? 2'd1 : 2'd0); // R03
    end
  endfunction

  // search: unmasked lowest first, then masked lowest
  reg        hit_u;
  reg        hit_m;
  reg [3:0]  idx_u;
  reg [3:0]  idx_m;
  reg [1:0]  src;
  reg [28:0] mk;
  reg        ok;
  integer    i;
  always @*
  begin
    hit_u = 1'b0;
    hit_m = 1'b0;
    idx_u = 4'h0;
    idx_m = 4'h0;
    src   = 2'd0;
    mk    = 29'h0;
    ok    = 1'b0;
    for (i = NBUF - 1; i >= 0; i = i - 1)
    begin
      src = msrc(i[3:0], m0, m1, glob);
      mk  = (src == 2'd1) ? buf_mem[0][`CRMR_BUF_ID] :
            (src == 2'd2) ? buf_mem[2][`CRMR_BUF_ID] : 29'h0;
      ok  = buf_mem[i][`CRMR_BUF_EN] && (src != 2'd3) // R09
            && !(lock_eff_q && (sel == i[3:0])) // R12
            && cmp(buf_mem[i], rx_id, rx_ide, mk); // R08
      if (ok && src == 2'd0)
      begin
        hit_u = 1'b1;
        idx_u = i[3:0]; // R10
      end
      if (ok && src != 2'd0)
      begin
        hit_m = 1'b1;
        idx_m = i[3:0];
      end
    end
  end

  // prepare stage then store stage
  always @(posedge clk)
  begin
    if (reset)
    begin
      pend_q         <= 1'b0;
      pend_buf_q     <= 4'h0;
      pend_msk_q     <= 1'b0;
      pend_id_q      <= 29'h0;
      store_valid_q  <= 1'b0;
      store_buf_q    <= 4'h0;
      store_masked_q <= 1'b0;
    end
    else
    begin
      pend_q        <= rx_valid && (hit_u || hit_m) && !init_req_q;
      pend_buf_q    <= hit_u ? idx_u : idx_m; // R11
      pend_msk_q    <= !hit_u;
      pend_id_q     <= rx_id;
      store_valid_q <= pend_q;
      if (pend_q)
      begin
        store_buf_q    <= pend_buf_q;
        store_masked_q <= pend_msk_q;
      end
    end
  end

  // lock takes hold only when no store targets the selection
  always @(posedge clk)
  begin
    if (reset)
      lock_eff_q <= 1'b0;
    else if (!lock)
      lock_eff_q <= 1'b0;
    else if (!(pend_q && pend_buf_q == sel)) // R16
      lock_eff_q <= 1'b1;
  end

  // buffer words: software writes, masked store rewrites id
  always @(posedge clk)
  begin
    if (pend_q && pend_msk_q)
      buf_mem[pend_buf_q][`CRMR_BUF_ID] <= pend_id_q; // R17
    if (wr && is_bf && !(pend_q && pend_msk_q && pend_buf_q == bidx))
      buf_mem[bidx] <= pwdata;
  end

  // control, mask and redefine registers
  always @(posedge clk)
  begin
    if (reset)
    begin
      init_req_q  <= 1'b0;
      init_conf_q <= 1'b0;
      mask_ctrl_q <= `CRMR_RST_BYTE;
      redef_q     <= `CRMR_RST_BYTE;
    end
    else
    begin
      // confirmation waits for the store pipe to drain
      init_conf_q <= init_req_q && !pend_q && !store_valid_q;
      if (wr && paddr == `CRMR_OFS_CTRL)
        init_req_q <= pwdata[`CRMR_CTRL_INIT];
      if (wr && paddr == `CRMR_OFS_MASK && init_conf_q) // R07
        mask_ctrl_q <= pwdata[7:0] & `CRMR_MASK_WMASK;
      if (wr && paddr == `CRMR_OFS_REDEF)
        redef_q <= pwdata[7:0] & `CRMR_REDEF_WMASK; // R14 R15 R19
      if (init_req_q)
        redef_q[`CRMR_REDEF_LOCK] <= 1'b0; // R13
    end
  end

  // new data flags: store sets, write one clears, set wins
  always @(posedge clk)
  begin
    if (reset || init_req_q)
      new_data_q <= 16'h0;
    else
    begin
      if (wr && paddr == `CRMR_OFS_NEWD)
        new_data_q <= new_data_q & ~pwdata[15:0];
      if (pend_q)
        new_data_q[pend_buf_q] <= 1'b1; // R17
    end
  end

  // single shot handling of transmit outcomes
  always @(posedge clk)
  begin
    if (reset)
    begin
      tx_retry_q   <= 1'b0;
      tx_drop_q    <= 1'b0;
      used_retry_q <= 1'b0;
    end
    else
    begin
      tx_retry_q <= 1'b0;
      tx_drop_q  <= 1'b0;
      if (tx_start && !used_retry_q)
        used_retry_q <= 1'b0;
      if (tx_done || init_req_q)
        used_retry_q <= 1'b0;
      if (tx_err)
      begin
        tx_retry_q <= !one; // R04
        tx_drop_q  <= one; // R05 R06
        used_retry_q <= 1'b0;
      end
      else if (tx_arb_lost)
      begin
        if (!one)
          tx_retry_q <= 1'b1; // R04
        else if (rq && !used_retry_q)
        begin
          tx_retry_q   <= 1'b1; // R06
          used_retry_q <= 1'b1;
        end
        else
        begin
          tx_drop_q    <= 1'b1; // R05
          used_retry_q <= 1'b0;
        end
      end
    end
  end

  // read mux
  reg [31:0] rd;
  reg        bad;
  always @*
  begin
    rd  = `CRMR_RST_WORD;
    bad = 1'b0;
    if (is_bf)
      rd = buf_mem[bidx];
    else
      case (paddr)
        `CRMR_OFS_CTRL:
          rd = {30'h0, init_conf_q, init_req_q};
        `CRMR_OFS_MASK:
          rd = {24'h0, mask_ctrl_q};
        `CRMR_OFS_REDEF:
          rd = {24'h0, redef_q}; // R19
        `CRMR_OFS_NEWD:
          rd = {16'h0, new_data_q};
        `CRMR_OFS_STAT:
          rd = {23'h0, lock_eff_q, 3'h0, store_masked_q, store_buf_q};
        default:
          bad = 1'b1;
      endcase
  end

  // apb answer one cycle into the access phase
  always @(posedge clk)
  begin
    if (reset)
    begin
      pready_q  <= 1'b0;
      prdata_q  <= `CRMR_RST_WORD;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q  <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && bad;
      if (psel && penable && !pready_q && !pwrite)
        prdata_q <= rd;
    end
  end

endmodule // crmr_top

// file: bench/crmr_checker.sv
`timescale 1ns/100ps
module crmr_checker (
  // clock and reset
  input wire        clk,
  input wire        reset,
  // apb answer
  input wire        psel,
  input wire        penable,
  input wire        pready_q,
  input wire [31:0] prdata_q,
  input wire        pslverr_q,
  // frames and outcomes
  input wire        rx_valid,
  input wire        store_valid_q,
  input wire [3:0]  store_buf_q,
  input wire        tx_err,
  input wire        tx_arb_lost,
  input wire        tx_retry_q,
  input wire        tx_drop_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // apb answers after exactly one wait
  chk_apb_wait: assert property (psel && penable && !pready_q |=> pready_q)
    else $error("ready late");
  chk_apb_pulse: assert property (pready_q |=> !pready_q)
    else $error("ready held");
  chk_err_ready: assert property (pslverr_q |-> pready_q)
    else $error("error without ready");
  chk_rdata_hold: assert property (!pready_q |-> $stable(prdata_q))
    else $error("read data moved");
  // a store only two cycles after a frame
  chk_store_lat: assert property (store_valid_q |-> $past(rx_valid, 2))
    else $error("store without frame");
  chk_buf_hold: assert property (!store_valid_q |-> $stable(store_buf_q))
    else $error("buffer number moved");
  // outcomes only follow a loss or an error
  chk_retry_cause: assert property (tx_retry_q |-> $past(tx_err) || $past(tx_arb_lost))
    else $error("retry without cause");
  chk_drop_cause: assert property (tx_drop_q |-> $past(tx_err) || $past(tx_arb_lost))
    else $error("drop without cause");
  chk_tx_excl: assert property (!(tx_retry_q && tx_drop_q))
    else $error("retry and drop together");
  cover property (store_valid_q);
  cover property (tx_drop_q);
  cover property (pslverr_q);
endmodule // crmr_checker
bind crmr_top crmr_checker crmr_checker_inst (.clk(clk), .reset(reset), .psel(psel),
  .penable(penable), .pready_q(pready_q), .prdata_q(prdata_q), .pslverr_q(pslverr_q),
  .rx_valid(rx_valid), .store_valid_q(store_valid_q), .store_buf_q(store_buf_q),
  .tx_err(tx_err), .tx_arb_lost(tx_arb_lost), .tx_retry_q(tx_retry_q),
  .tx_drop_q(tx_drop_q));

// file: bench/crmr_engine_model.sv
`timescale 1ns/100ps
module crmr_engine_model (
  // clock
  input wire         clk,
  // received frame
  output logic        rx_valid,
  output logic [28:0] rx_id,
  output logic        rx_ide,
  // transmit events
  output logic        tx_start,
  output logic        tx_err,
  output logic        tx_arb_lost,
  output logic        tx_done
);
  initial
  begin
    {rx_valid, rx_id, rx_ide, tx_start, tx_err, tx_arb_lost, tx_done} = '0;
  end
  // one-cycle frame; id inverted after so stale values never match
  task frame(input [28:0] id, input e);
    begin
      @(posedge clk);
      {rx_valid, rx_id, rx_ide} <= {1'b1, id, e};
      @(posedge clk);
      {rx_valid, rx_id, rx_ide} <= {1'b0, ~id, ~e};
    end
  endtask
  // one-cycle event pulse: start, loss, error, done
  task ev(input [3:0] v);
    begin
      @(posedge clk);
      {tx_start, tx_arb_lost, tx_err, tx_done} <= v;
      @(posedge clk);
      {tx_start, tx_arb_lost, tx_err, tx_done} <= 4'h0;
    end
  endtask
endmodule // crmr_engine_model

// file: bench/tb_crmr_top.sv
`timescale 1ns/100ps
`include "crmr_map.vh"
module tb_crmr_top;
  logic        clk = 0;
  logic        reset = 1;
  logic        psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  wire         pready_q, pslverr_q, store_valid_q, store_masked_q, tx_retry_q, tx_drop_q;
  wire  [31:0] prdata_q;
  wire  [3:0]  store_buf_q;
  wire         rx_valid, rx_ide, tx_start, tx_err, tx_arb_lost, tx_done;
  wire  [28:0] rx_id;
  int          failures, checked, k, j;
  logic [33:0] an;
  logic [4:0]  sn;
  logic [10:0] id1, id2, id3;
  logic [33:0] aq[$];
  logic [4:0]  sq[$];
  logic [1:0]  tq[$];
  logic [5:0]  te[3] = '{6'h2a, 6'h15, 6'h25};
  always #5 clk = ~clk;
  crmr_top #(.NBUF(16)) crmr_top_inst (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready_q(pready_q),
    .prdata_q(prdata_q), .pslverr_q(pslverr_q), .rx_valid(rx_valid), .rx_id(rx_id),
    .rx_ide(rx_ide), .store_valid_q(store_valid_q), .store_buf_q(store_buf_q),
    .store_masked_q(store_masked_q), .tx_start(tx_start), .tx_err(tx_err),
    .tx_arb_lost(tx_arb_lost), .tx_done(tx_done), .tx_retry_q(tx_retry_q),
    .tx_drop_q(tx_drop_q));
  crmr_engine_model crmr_engine_model_inst (.clk(clk), .rx_valid(rx_valid), .rx_id(rx_id),
    .rx_ide(rx_ide), .tx_start(tx_start), .tx_err(tx_err), .tx_arb_lost(tx_arb_lost),
    .tx_done(tx_done));
  task chk(input string s, input [31:0] v, input [31:0] e);
    begin
      checked++;
      if (v !== e)
      begin
        failures++;
        $display("[FAIL] %s exp %h got %h", s, e, v);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // apb transfer; read expectation rides in d
  task apb(input w, input [7:0] a, input [31:0] d, input er);
    int n;
    begin
      aq.push_back({!w, er, d});
      @(posedge clk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
        @(posedge clk);
        n++;
      end while (!pready_q && n < 9);
      if (n >= 9)
      begin
        failures++;
        give_verdict;
      end
      {psel, penable} <= 2'b00;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    apb(1'b0, a, e, 1'b0);
  endtask
  // mask setup only inside confirmed init
  task mode(input [7:0] m);
    begin
      wr(`CRMR_OFS_CTRL, 32'h1);
      wr(`CRMR_OFS_MASK, {24'h0, m});
      wr(`CRMR_OFS_CTRL, 32'h0);
    end
  endtask
  task rx(input [4:0] e, input [10:0] id);
    begin
      sq.push_back(e);
      crmr_engine_model_inst.frame({id, 18'h0}, 1'b0);
    end
  endtask
  // watcher: oldest note against each result
  always @(posedge clk)
  begin
    if (pready_q)
    begin
      an = aq.pop_front();
      chk("slverr", {31'h0, pslverr_q}, {31'h0, an[32]});
      if (an[33])
        chk("prdata", prdata_q, an[31:0]);
    end
    // an unexpected store must not hide behind an empty queue
    if (store_valid_q)
    begin
      chk("store_noted", {31'h0, sq.size() == 0}, 32'h0);
      sn = (sq.size() != 0) ? sq.pop_front() : 5'h1f;
      chk("store", {27'h0, store_masked_q, store_buf_q}, {27'h0, sn});
    end
    if (tx_retry_q || tx_drop_q)
      chk("tx", {30'h0, tx_retry_q, tx_drop_q}, {30'h0, tq.pop_front()});
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    void'($urandom(80193));
    id1 = 11'($urandom);
    id2 = id1 ^ 11'h7ff;
    id3 = id1 ^ 11'h555;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    for (k = 0; k < 5; k++)
      rd(8'(k * 4), 32'h0);
    apb(1'b1, 8'h20, 32'h0, 1'b1);
    wr(`CRMR_OFS_MASK, 32'h37);
    rd(`CRMR_OFS_MASK, 32'h0);
    wr(`CRMR_OFS_CTRL, 32'h1);
    rd(`CRMR_OFS_CTRL, 32'h3);
    for (k = 0; k < 16; k++)
      wr(8'(64 + k * 4), {3'b010, id1, 18'h0});
    wr(`CRMR_OFS_CTRL, 32'h0);
    rx(5'h00, id1);
    crmr_engine_model_inst.frame({id1, 18'h0}, 1'b1);
    wr(8'h40, 32'h1fff_ffff);
    mode(8'h01);
    rx(5'h02, id1);
    rd(`CRMR_OFS_NEWD, 32'h4);
    wr(`CRMR_OFS_NEWD, 32'h4);
    wr(`CRMR_OFS_REDEF, 32'h02);
    // lock lands on the edge that takes a frame for buffer 2
    fork
      wr(`CRMR_OFS_REDEF, 32'hf2);
      begin
        repeat (2) @(posedge clk);
        rx(5'h02, id1);
      end
    join
    rd(`CRMR_OFS_NEWD, 32'h4);
    wr(8'h48, {3'b010, id1, 18'h0});
    rd(`CRMR_OFS_REDEF, 32'h82);
    rx(5'h03, id1);
    wr(`CRMR_OFS_CTRL, 32'h1);
    rd(`CRMR_OFS_REDEF, 32'h02);
    wr(`CRMR_OFS_CTRL, 32'h0);
    rx(5'h11, id2);
    rd(8'h44, {3'b010, id2, 18'h0});
    mode(8'h05);
    rx(5'h11, id1);
    wr(8'h48, 32'h1fff_ffff);
    mode(8'h02);
    rx(5'h13, id3);
    // single-shot table: loss, loss, error
    for (k = 0; k < 3; k++)
    begin
      mode(k == 0 ? 8'h00 : (k == 1 ? 8'h20 : 8'h30));
      crmr_engine_model_inst.ev(4'h8);
      for (j = 0; j < 3; j++)
      begin
        tq.push_back(te[k][5 - 2 * j -: 2]);
        crmr_engine_model_inst.ev(j < 2 ? 4'h4 : 4'h2);
      end
    end
    crmr_engine_model_inst.ev(4'h1);
    repeat (5) @(posedge clk);
    chk("left", aq.size() + sq.size() + tq.size(), 32'h0);
    give_verdict;
  end
endmodule // tb_crmr_top
